// [core/atc_top.sv]
// Contract
// R1: Trigger only when all selected conditions hold.
// R2: While armed, keep samples for pre-trigger part.
// R3: After trigger, fill post part, then stop.
// R4: Ignore triggers until capture and holdoff end.
// R5: Edge mode fires on threshold crossing.
// R6: Slope picks rising, falling or both.
// R7: Both slopes: first crossing after start fires.
// R8: Sources: analog, external, line, D0-D15, bus.
// R9: Source works whether displayed or not.
// R10: External source allows only edge type.
// R11: Digital sources allow edge, width, timeout only; width is not built and never fires.
// R12: Line source from mains, edge type only.
// R13: Find level sets half of max minus min.
// R14: Find level refused for external and line.
// R15: Knob press sets level to amplitude midpoint.
// R16: Only single-event triggering is supported.
// R17: External trigger only in single-event operation.
// R18: Timeout threshold separates high from low.
// R19: Runt, window, slew use upper and lower levels; only window is built, runt and slew never fire.
// R20: External filter off, low-band or high-band block.
// R21: Noise reject adds hysteresis on external edge.
// R22: Recognised trigger drives trigger-out when enabled.
// R23: Holdoff counts samples after post fill completes.
// R24: Clear resets arming, counters and trigger-out.
//
// The address map and the AHB-Lite slave port were decided locally.
`default_nettype none
module atc_top
	import atc_pkg::*;
#(
	parameter int SW = 12,
	parameter int NCH = 8,
	parameter int DEPTH = 256
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic sample_en,
	input wire logic [NCH*SW-1:0] ach_data,
	input wire logic [SW-1:0] ext_data,
	input wire logic [SW-1:0] line_data,
	input wire logic [15:0] dig_data,
	input wire logic bus_hit,
	output logic trig_out,
	output logic capturing
);
	localparam int AW = $clog2(DEPTH);
	localparam int E = SW + 2;
	typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_ARMED, ST_POST, ST_HOLD} atc_state_e;

	// ****************************************************************
	// Registers and state
	// ****************************************************************
	atc_state_e st;
	atc_cfg_s cfg;
	atc_req_s dph;
	logic run, tout_en, refused;
	logic [SW-1:0] level, upper, lower, avg, pk_max, pk_min;
	logic [15:0] pre_len, post_len, hold_len, tmo_len, cnt, tcnt;
	logic [7:0] trig_cnt;
	logic [AW-1:0] wp, trig_pos, rd_idx;
	logic [SW-1:0] mem [DEPTH];
	logic hi, hi_vld, out_q;

	logic [SW-1:0] x, ext_f;
	logic dbit, next_hi, rise, fall, out_now, evt, cond_ok, fire, clr, wr_now;
	logic find_req, mid_req, lock_src;
	logic [E-1:0] hys, up_th, dn_th;
	logic [SW:0] diff;
	logic [31:0] rd_val;

	function automatic logic type_ok(atc_cfg_s c);
		case (c.kind)
			ATC_K_EXT, ATC_K_LINE, ATC_K_BUS: type_ok = (c.ttype == ATC_T_EDGE); // R10 R12
			ATC_K_DIG: type_ok = (c.ttype == ATC_T_EDGE) || (c.ttype == ATC_T_WIDTH) ||
				(c.ttype == ATC_T_TIMEOUT); // R11
			ATC_K_ANALOG: type_ok = 1'b1;
			default: type_ok = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] word(logic [SW-1:0] v);
		word = 32'(v);
	endfunction

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	// Zero wait states; a read that directly follows a write to the same
	// register returns the old value, since read data is taken at the address phase.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph <= '0;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			dph.sel <= hsel && hready && htrans[1];
			dph.wr <= hwrite;
			dph.addr <= haddr[7:0];
			if (hsel && hready && htrans[1] && !hwrite) begin
				hrdata <= rd_val;
			end
		end
	end

	assign wr_now = dph.sel && dph.wr;

	always_comb begin
		rd_val = 32'h0000_0000;
		case (haddr[7:0])
			ATC_CTRL: begin
				rd_val[ATC_CTRL_RUN] = run;
				rd_val[ATC_CTRL_TOUT] = tout_en;
			end
			ATC_SETUP: rd_val = 32'(cfg);
			ATC_LEVEL: rd_val = word(level);
			ATC_UPPER: rd_val = word(upper);
			ATC_LOWER: rd_val = word(lower);
			ATC_PRE: rd_val = 32'(pre_len);
			ATC_POST: rd_val = 32'(post_len);
			ATC_HOLD: rd_val = 32'(hold_len);
			ATC_TMO: rd_val = 32'(tmo_len);
			ATC_STATUS: begin
				rd_val[2:0] = st;
				rd_val[ATC_ST_BAD] = !cond_ok;
				rd_val[ATC_ST_REFUSED] = refused;
				rd_val[ATC_ST_CNT +: 8] = trig_cnt;
			end
			ATC_PEAK: rd_val = (word(pk_max) << ATC_PEAK_MAX) | word(pk_min);
			ATC_RDIDX: rd_val = 32'(rd_idx);
			ATC_RDDATA: rd_val = word(mem[rd_idx]);
			ATC_TRIGPOS: rd_val = 32'(trig_pos);
			default: rd_val = 32'h0000_0000;
		endcase
	end

	assign clr = wr_now && (dph.addr == ATC_CTRL) && hwdata[ATC_CTRL_CLR];
	assign find_req = wr_now && (dph.addr == ATC_CTRL) && hwdata[ATC_CTRL_FIND];
	assign mid_req = wr_now && (dph.addr == ATC_CTRL) && hwdata[ATC_CTRL_MID];
	assign lock_src = (cfg.kind == ATC_K_EXT) || (cfg.kind == ATC_K_LINE);

	// Single-event is the only trigger-on mode, so no sequence control exists. R16 R17
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run <= 1'b0;
			tout_en <= 1'b0;
			cfg <= '0;
			level <= '0;
			upper <= '0;
			lower <= '0;
			pre_len <= ATC_PRE_RST;
			post_len <= ATC_POST_RST;
			hold_len <= ATC_HOLD_RST;
			tmo_len <= ATC_TMO_RST;
			rd_idx <= '0;
		end else if (wr_now) begin
			case (dph.addr)
				ATC_CTRL: begin
					run <= hwdata[ATC_CTRL_RUN] && !hwdata[ATC_CTRL_CLR]; // R24
					tout_en <= hwdata[ATC_CTRL_TOUT];
					if (find_req && !lock_src) begin
						level <= SW'((pk_max - pk_min) >> 1); // R13 R14
					end else if (mid_req) begin
						level <= SW'(({1'b0, pk_max} + {1'b0, pk_min}) >> 1); // R15
					end
				end
				ATC_SETUP: cfg <= atc_cfg_s'(hwdata[ATC_CFG_W-1:0]);
				ATC_LEVEL: level <= hwdata[SW-1:0];
				ATC_UPPER: upper <= hwdata[SW-1:0]; // R19
				ATC_LOWER: lower <= hwdata[SW-1:0]; // R19
				ATC_PRE: pre_len <= hwdata[15:0];
				ATC_POST: post_len <= hwdata[15:0];
				ATC_HOLD: hold_len <= hwdata[15:0];
				ATC_TMO: tmo_len <= hwdata[15:0];
				ATC_RDIDX: rd_idx <= hwdata[AW-1:0];
				default: begin
				end
			endcase
		end
	end

	// A refused find sets the flag; a write of one to it clears, but a new refusal wins.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			refused <= 1'b0;
		end else if (find_req && lock_src) begin
			refused <= 1'b1; // R14
		end else if (wr_now && (dph.addr == ATC_STATUS) && hwdata[ATC_ST_REFUSED]) begin
			refused <= 1'b0;
		end
	end

	// ****************************************************************
	// Source selection and conditioning
	// ****************************************************************
	// The filter is a one-pole average; it costs settling time after a source change.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			avg <= '0;
		end else if (sample_en) begin
			avg <= avg + SW'($signed(diff) >>> ATC_FILT_K); // R20
		end
	end

	assign diff = {1'b0, ext_data} - {1'b0, avg};

	always_comb begin
		case (cfg.filt)
			ATC_F_LOW_BAND_BLOCK: ext_f = ext_data - avg + SW'(1 << (SW - 1)); // R20
			ATC_F_HIGH_BAND_BLOCK: ext_f = avg; // R20
			default: ext_f = ext_data;
		endcase
	end

	// The selection does not depend on what is displayed. R9
	always_comb begin
		x = '0;
		dbit = 1'b0;
		case (cfg.kind) // R8
			ATC_K_ANALOG: begin
				for (int i = 0; i < NCH; i++) begin
					if (cfg.idx == 4'(i)) begin
						x = ach_data[i*SW +: SW];
					end
				end
			end
			ATC_K_EXT: x = ext_f;
			ATC_K_LINE: x = line_data; // R12
			ATC_K_DIG: begin
				dbit = dig_data[cfg.idx];
				x = dbit ? '1 : '0;
			end
			default: x = '0;
		endcase
	end

	// Hysteresis only for the external edge with noise reject on. R21
	assign hys = (cfg.noise_rej && cfg.kind == ATC_K_EXT) ? E'(ATC_HYS) : '0;
	assign up_th = {2'b00, level} + hys;
	assign dn_th = {2'b00, level} - hys;

	always_comb begin
		if (cfg.kind == ATC_K_DIG) begin
			next_hi = dbit;
		end else if ($signed({2'b00, x}) >= $signed(up_th)) begin
			next_hi = 1'b1; // R18
		end else if ($signed({2'b00, x}) < $signed(dn_th)) begin
			next_hi = 1'b0; // R18
		end else begin
			next_hi = hi;
		end
	end

	assign rise = hi_vld && !hi && next_hi;
	assign fall = hi_vld && hi && !next_hi;
	assign out_now = (x > upper) || (x < lower); // R19

	// ****************************************************************
	// Event qualification
	// ****************************************************************
	always_comb begin
		evt = 1'b0;
		case (cfg.ttype)
			ATC_T_EDGE: begin
				if (cfg.kind == ATC_K_BUS) begin
					evt = bus_hit;
				end else begin
					case (cfg.slope) // R5 R6
						ATC_SL_POS: evt = rise;
						ATC_SL_NEG: evt = fall;
						ATC_SL_EITHER: evt = rise || fall; // R7
						default: evt = 1'b0;
					endcase
				end
			end
			ATC_T_WINDOW: evt = hi_vld && !out_q && out_now; // R19
			ATC_T_TIMEOUT: begin
				evt = hi_vld && (next_hi == hi) && (tcnt == tmo_len - 16'h0001); // R18
				if (cfg.slope == ATC_SL_POS) begin
					evt = evt && hi;
				end else if (cfg.slope == ATC_SL_NEG) begin
					evt = evt && !hi;
				end
			end
			default: evt = 1'b0;
		endcase
	end

	// Width and the other pulse comparators are not built; such setups never fire.
	assign cond_ok = type_ok(cfg) && (cfg.ttype == ATC_T_EDGE || cfg.ttype == ATC_T_WINDOW ||
		cfg.ttype == ATC_T_TIMEOUT);
	assign fire = sample_en && (st == ST_ARMED) && cond_ok && evt && !clr; // R1 R4

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hi <= 1'b0;
			hi_vld <= 1'b0;
			out_q <= 1'b0;
			tcnt <= '0;
		end else if (st == ST_IDLE || clr || (wr_now && dph.addr == ATC_SETUP)) begin
			hi_vld <= 1'b0; // R7
			tcnt <= '0;
		end else if (sample_en) begin
			hi <= next_hi;
			hi_vld <= 1'b1;
			out_q <= out_now;
			if (next_hi != hi) begin
				tcnt <= '0;
			end else if (tcnt != '1) begin
				tcnt <= tcnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pk_max <= '0;
			pk_min <= '1;
		end else if (clr || (wr_now && dph.addr == ATC_SETUP)) begin
			pk_max <= '0;
			pk_min <= '1;
		end else if (sample_en && st != ST_IDLE) begin
			if (x > pk_max) begin
				pk_max <= x;
			end
			if (x < pk_min) begin
				pk_min <= x;
			end
		end
	end

	// ****************************************************************
	// Acquisition sequencing
	// ****************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= ST_IDLE;
			cnt <= '0;
		end else if (clr) begin
			st <= ST_IDLE; // R24
			cnt <= '0;
		end else begin
			case (st)
				ST_IDLE: begin
					cnt <= '0;
					if (run) begin
						st <= ST_PRE;
					end
				end
				ST_PRE: begin
					if (!run) begin
						st <= ST_IDLE;
					end else if (cnt >= pre_len) begin
						st <= ST_ARMED; // R2
					end else if (sample_en) begin
						cnt <= cnt + 16'h0001;
					end
				end
				ST_ARMED: begin
					cnt <= '0;
					if (!run) begin
						st <= ST_IDLE;
					end else if (fire) begin
						st <= ST_POST; // R3
					end
				end
				ST_POST: begin
					if (cnt >= post_len) begin
						st <= ST_HOLD; // R3
						cnt <= '0;
					end else if (sample_en) begin
						cnt <= cnt + 16'h0001;
					end
				end
				ST_HOLD: begin
					if (cnt >= hold_len) begin
						st <= run ? ST_PRE : ST_IDLE; // R4
						cnt <= '0;
					end else if (sample_en) begin
						cnt <= cnt + 16'h0001; // R23
					end
				end
				default: begin
					st <= ST_IDLE;
					cnt <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge hclk) begin
		if (sample_en && (st == ST_PRE || st == ST_ARMED || st == ST_POST)) begin
			mem[wp] <= x; // R2
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp <= '0;
			trig_pos <= '0;
			trig_cnt <= '0;
		end else if (clr) begin
			wp <= '0;
			trig_cnt <= '0;
		end else begin
			if (sample_en && (st == ST_PRE || st == ST_ARMED || st == ST_POST)) begin
				wp <= wp + AW'(1);
			end
			if (fire) begin
				trig_pos <= wp;
				trig_cnt <= trig_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trig_out <= 1'b0;
			capturing <= 1'b0;
		end else begin
			trig_out <= fire && tout_en && !clr; // R22 R24
			capturing <= (st == ST_PRE || st == ST_ARMED || st == ST_POST) && !clr;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_fire;
		fire;
	endsequence
	sequence s_post_done;
		st == ST_POST ##1 st == ST_HOLD;
	endsequence

	fire_when_armed_a: assert property (fire |-> st == ST_ARMED && cond_ok) // R1
		else $error("trigger outside armed state");
	fire_to_post_a: assert property (s_fire |=> st == ST_POST) // R3
		else $error("trigger did not start post fill");
	no_rearm_a: assert property (st == ST_POST || st == ST_HOLD |-> !fire) // R4
		else $error("trigger accepted during capture or holdoff");
	rise_fires_a: assert property (sample_en && st == ST_ARMED && cfg.ttype == ATC_T_EDGE &&
		cfg.kind != ATC_K_BUS && cfg.slope == ATC_SL_POS && cond_ok && rise && !clr
		|-> fire) // R5
		else $error("rising crossing missed");
	slope_block_a: assert property (cfg.ttype == ATC_T_EDGE && cfg.slope == ATC_SL_NEG &&
		cfg.kind != ATC_K_BUS && !fall |-> !fire) // R6
		else $error("trigger without falling crossing");
	ext_type_a: assert property (cfg.kind == ATC_K_EXT && cfg.ttype != ATC_T_EDGE
		|-> !cond_ok) // R10
		else $error("external source accepted non-edge type");
	dig_type_a: assert property (cfg.kind == ATC_K_DIG && fire
		|-> cfg.ttype == ATC_T_EDGE || cfg.ttype == ATC_T_TIMEOUT) // R11
		else $error("digital source fired with illegal type");
	find_refuse_a: assert property (find_req && lock_src && !(wr_now && dph.addr == ATC_LEVEL)
		|=> level == $past(level) ##0 refused) // R14
		else $error("find level acted on external or line");
	tout_pulse_a: assert property (s_fire ##0 tout_en |=> trig_out ##1 !trig_out || fire) // R22
		else $error("trigger-out pulse wrong");
	hold_start_a: assert property (s_post_done |-> cnt == 16'h0000) // R23
		else $error("holdoff did not start from zero");
	clear_all_a: assert property (clr |=> st == ST_IDLE && cnt == 16'h0000 && !trig_out &&
		!run) // R24
		else $error("clear left state behind");
endmodule
`default_nettype wire

// [core/atc_pkg.sv]
`default_nettype none
// ****************************************************************
// Trigger control constants
// ****************************************************************
package atc_pkg;
	localparam logic [7:0] ATC_CTRL = 8'h00;
	localparam logic [7:0] ATC_SETUP = 8'h04;
	localparam logic [7:0] ATC_LEVEL = 8'h08;
	localparam logic [7:0] ATC_UPPER = 8'h0c;
	localparam logic [7:0] ATC_LOWER = 8'h10;
	localparam logic [7:0] ATC_PRE = 8'h14;
	localparam logic [7:0] ATC_POST = 8'h18;
	localparam logic [7:0] ATC_HOLD = 8'h1c;
	localparam logic [7:0] ATC_TMO = 8'h20;
	localparam logic [7:0] ATC_STATUS = 8'h24;
	localparam logic [7:0] ATC_PEAK = 8'h28;
	localparam logic [7:0] ATC_RDIDX = 8'h2c;
	localparam logic [7:0] ATC_RDDATA = 8'h30;
	localparam logic [7:0] ATC_TRIGPOS = 8'h34;
	localparam int ATC_CTRL_RUN = 0;
	localparam int ATC_CTRL_TOUT = 1;
	localparam int ATC_CTRL_FIND = 2;
	localparam int ATC_CTRL_MID = 3;
	localparam int ATC_CTRL_CLR = 4;
	localparam int ATC_ST_BAD = 3;
	localparam int ATC_ST_REFUSED = 4;
	localparam int ATC_ST_CNT = 8;
	localparam int ATC_PEAK_MAX = 16;
	localparam int ATC_FILT_K = 4;
	localparam int ATC_HYS = 8;
	localparam logic [15:0] ATC_PRE_RST = 16'h0040;
	localparam logic [15:0] ATC_POST_RST = 16'h00c0;
	localparam logic [15:0] ATC_HOLD_RST = 16'h0000;
	localparam logic [15:0] ATC_TMO_RST = 16'h0100;
	typedef enum logic [2:0] {ATC_K_ANALOG, ATC_K_EXT, ATC_K_LINE, ATC_K_DIG, ATC_K_BUS} atc_kind_e;
	typedef enum logic [2:0] {ATC_T_EDGE, ATC_T_GLITCH, ATC_T_WIDTH, ATC_T_RUNT, ATC_T_WINDOW,
		ATC_T_TIMEOUT, ATC_T_INTERVAL, ATC_T_SLEW} atc_type_e;
	typedef enum logic [1:0] {ATC_SL_POS, ATC_SL_NEG, ATC_SL_EITHER} atc_slope_e;
	typedef enum logic [1:0] {ATC_F_OFF, ATC_F_LOW_BAND_BLOCK, ATC_F_HIGH_BAND_BLOCK} atc_filt_e;
	typedef struct packed {
		logic noise_rej;
		atc_filt_e filt;
		atc_slope_e slope;
		atc_type_e ttype;
		logic [3:0] idx;
		atc_kind_e kind;
	} atc_cfg_s;
	localparam int ATC_CFG_W = $bits(atc_cfg_s);
	typedef struct packed {
		logic sel;
		logic wr;
		logic [7:0] addr;
	} atc_req_s;
endpackage
`default_nettype wire

// [core/atc_unused_none.sv]
`default_nettype none
`default_nettype wire

// [dv/atc_chan_model.sv]
`default_nettype none
// ****************************************************************
// Sampled channel source
// ****************************************************************
// Off the strobe every data line flips, so logic that reads data without
// the strobe sees a changing pattern rather than a lucky stale value.
module atc_chan_model
	import atc_pkg::*;
#(
	parameter int SW = 12,
	parameter int NCH = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [1:0] gap,
	input wire logic [SW-1:0] code,
	input wire atc_kind_e kind,
	input wire logic [3:0] idx,
	output logic sample_en,
	output logic [NCH*SW-1:0] ach_data,
	output logic [SW-1:0] ext_data,
	output logic [SW-1:0] line_data,
	output logic [15:0] dig_data,
	output logic bus_hit
);
	logic [1:0] cnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 2'h0;
			sample_en <= 1'b0;
			ach_data <= '0;
			ext_data <= '0;
			line_data <= '0;
			dig_data <= 16'h0000;
			bus_hit <= 1'b0;
		end else if (cnt == 2'h0) begin
			cnt <= gap;
			sample_en <= 1'b1;
			for (int i = 0; i < NCH; i++) begin
				ach_data[i*SW +: SW] <= (kind == ATC_K_ANALOG && idx == 4'(i)) ? code : ~code;
			end
			ext_data <= (kind == ATC_K_EXT) ? code : ~code;
			line_data <= (kind == ATC_K_LINE) ? code : ~code;
			for (int i = 0; i < 16; i++) begin
				dig_data[i] <= (kind == ATC_K_DIG && idx == 4'(i)) ? code[SW-1] : ~code[SW-1];
			end
			bus_hit <= (kind == ATC_K_BUS) & code[SW-1];
		end else begin
			cnt <= cnt - 2'h1;
			sample_en <= 1'b0;
			ach_data <= ~ach_data;
			ext_data <= ~ext_data;
			line_data <= ~line_data;
			dig_data <= ~dig_data;
			bus_hit <= ~bus_hit;
		end
	end
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`default_nettype none
// ****************************************************************
// Trigger control bench
// ****************************************************************
module tb_top import atc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [1:0] gap = 2'h0;
	logic [11:0] code = 12'h000;
	atc_kind_e kind = ATC_K_ANALOG;
	logic [3:0] idx = 4'h0;
	logic [15:0] seed = 16'h0017;
	logic [31:0] rd;
	int num_errors = 0;
	int compares = 0;
	int pulses = 0;
	int cyc = 0;
	wire logic [31:0] hrdata;
	wire logic hreadyout;
	wire logic hresp;
	wire logic sample_en;
	wire logic bus_hit;
	wire logic trig_out;
	wire logic capturing;
	wire logic [95:0] ach_data;
	wire logic [11:0] ext_data;
	wire logic [11:0] line_data;
	wire logic [15:0] dig_data;

	atc_top #(.SW(12), .NCH(8), .DEPTH(256)) dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .sample_en(sample_en), .ach_data(ach_data), .ext_data(ext_data),
		.line_data(line_data), .dig_data(dig_data), .bus_hit(bus_hit),
		.trig_out(trig_out), .capturing(capturing));
	atc_chan_model #(.SW(12), .NCH(8)) model (.hclk(hclk), .hresetn(hresetn), .gap(gap),
		.code(code), .kind(kind), .idx(idx), .sample_en(sample_en), .ach_data(ach_data),
		.ext_data(ext_data), .line_data(line_data), .dig_data(dig_data), .bus_hit(bus_hit));

	always #25 hclk = ~hclk;
	// Counting on the falling edge keeps the tally clear of the tasks' edge.
	always @(negedge hclk) begin
		if (trig_out === 1'b1) begin
			pulses++;
		end
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			give_verdict();
		end
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		check({31'h0, hresp}, 32'h0, "response");
	endtask

	task automatic samples(input logic [11:0] c, input int n);
		code <= c;
		@(posedge hclk);
		repeat (n) begin
			do @(posedge hclk); while (sample_en !== 1'b1);
		end
	endtask

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic legal(input atc_cfg_s c);
		// Width is a legal digital type but has no comparator, so it counts as unusable.
		return c.ttype inside {ATC_T_EDGE, ATC_T_WINDOW, ATC_T_TIMEOUT} &&
			(c.kind == ATC_K_ANALOG || c.ttype == ATC_T_EDGE ||
			(c.kind == ATC_K_DIG && c.ttype == ATC_T_TIMEOUT));
	endfunction

	function automatic logic fires(input atc_cfg_s c, input logic [11:0] lo,
		input logic [11:0] hi);
		logic [11:0] h;
		h = (c.kind == ATC_K_EXT && c.noise_rej) ? 12'h008 : 12'h000;
		if (!legal(c)) begin
			return 1'b0;
		end
		if (c.kind inside {ATC_K_DIG, ATC_K_BUS}) begin
			return hi[11] && !lo[11] && c.ttype != ATC_T_WIDTH;
		end
		case (c.ttype)
			ATC_T_EDGE: return hi >= 12'h800 + h && lo < 12'h800 - h;
			ATC_T_WINDOW: return hi > 12'hc00 || lo < 12'h400;
			ATC_T_TIMEOUT: return hi >= 12'h800;
			default: return 1'b0;
		endcase
	endfunction

	// ****************************************************************
	// One capture: low, high, low, then clear
	// ****************************************************************
	task automatic go(input atc_cfg_s c, input logic [11:0] lo, input logic [11:0] hi,
		input logic tout, input logic pk);
		logic f;
		logic early;
		f = fires(c, lo, hi);
		early = f && !(c.ttype == ATC_T_EDGE && c.slope == ATC_SL_NEG);
		kind <= c.kind;
		idx <= c.idx;
		code <= lo;
		ahb(1'b1, ATC_SETUP, 32'(c));
		ahb(1'b1, ATC_LEVEL, 32'h800);
		ahb(1'b0, ATC_STATUS, 32'h0);
		check({31'h0, rd[ATC_ST_BAD]}, {31'h0, !legal(c)}, "unsupported flag");
		pulses = 0;
		ahb(1'b1, ATC_CTRL, {30'h0, tout, 1'b1});
		samples(lo, 4);
		samples(hi, 4);
		@(posedge hclk);
		check(32'(pulses), {31'h0, early & tout}, "pulses after rise");
		samples(lo, 4);
		repeat (2) @(posedge hclk);
		check(32'(pulses), {31'h0, f & tout}, "trigger pulses");
		ahb(1'b0, ATC_STATUS, 32'h0);
		check({24'h0, rd[15:8]}, {31'h0, f}, "trigger count");
		if (pk) begin
			ahb(1'b1, ATC_CTRL, {29'h0, 1'b1, tout, 1'b1});
			repeat (2) @(posedge hclk);
			ahb(1'b0, ATC_LEVEL, 32'h0);
			if (c.kind == ATC_K_ANALOG) begin
				check(rd, {20'h0, (hi - lo) >> 1}, "found level");
				ahb(1'b1, ATC_CTRL, {28'h0, 1'b1, 1'b0, tout, 1'b1});
				repeat (2) @(posedge hclk);
				ahb(1'b0, ATC_LEVEL, 32'h0);
				check(rd, {20'h0, 12'((13'(hi) + 13'(lo)) >> 1)}, "knob level");
			end else begin
				check(rd, 32'h800, "level kept");
			end
			ahb(1'b0, ATC_STATUS, 32'h0);
			check({31'h0, rd[ATC_ST_REFUSED]}, {31'h0, c.kind != ATC_K_ANALOG}, "refusal");
			ahb(1'b1, ATC_STATUS, 32'h10);
		end
		ahb(1'b1, ATC_CTRL, 32'h10);
		repeat (2) @(posedge hclk);
		check({30'h0, capturing, trig_out}, 32'h0, "outputs after clear");
		ahb(1'b0, ATC_STATUS, 32'h0);
		check({16'h0, rd[15:0] & 16'hff17}, 32'h0, "status after clear");
	endtask

	task automatic rgo(input atc_kind_e k, input atc_type_e t, input atc_slope_e s,
		input logic pk);
		atc_cfg_s c;
		seed = lfsr(seed);
		c = '{noise_rej: 1'b0, filt: ATC_F_OFF, slope: s, ttype: t, kind: k,
			idx: (k == ATC_K_DIG) ? seed[13:10] : {1'b0, seed[12:10]}};
		gap <= seed[1:0];
		go(c, 12'h400 | {2'h0, seed[9:0]}, 12'hc01 + {3'h0, seed[8:0]}, seed[15], pk);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		atc_cfg_s c;
		repeat (20) @(posedge hclk);
		check({29'h0, capturing, trig_out, hreadyout}, 32'h0, "reset outputs");
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		ahb(1'b0, ATC_PRE, 32'h0);
		check(rd, {16'h0, ATC_PRE_RST}, "pre length");
		ahb(1'b0, ATC_POST, 32'h0);
		check(rd, {16'h0, ATC_POST_RST}, "post length");
		ahb(1'b0, ATC_HOLD, 32'h0);
		check(rd, {16'h0, ATC_HOLD_RST}, "hold length");
		ahb(1'b0, ATC_TMO, 32'h0);
		check(rd, {16'h0, ATC_TMO_RST}, "timeout length");
		ahb(1'b1, 8'h3c, 32'hffffffff);
		ahb(1'b0, 8'h3c, 32'h0);
		check(rd, 32'h0, "unmapped read");
		ahb(1'b1, ATC_PRE, 32'h2);
		ahb(1'b1, ATC_POST, 32'h3);
		ahb(1'b1, ATC_HOLD, 32'h2);
		ahb(1'b1, ATC_TMO, 32'h3);
		ahb(1'b1, ATC_UPPER, 32'hc00);
		ahb(1'b1, ATC_LOWER, 32'h400);
		for (int s = 0; s < 3; s++) begin
			rgo(ATC_K_ANALOG, ATC_T_EDGE, atc_slope_e'(s), 1'b0);
		end
		for (int k = 0; k < 5; k++) begin
			for (int t = 0; t < 8; t++) begin
				rgo(atc_kind_e'(k), atc_type_e'(t), ATC_SL_POS, t == 0 && k < 3);
			end
		end
		c = '{noise_rej: 1'b1, filt: ATC_F_OFF, slope: ATC_SL_POS, ttype: ATC_T_EDGE,
			idx: 4'h0, kind: ATC_K_EXT};
		go(c, 12'h7f0, 12'h804, 1'b1, 1'b0);
		go(c, 12'h7f0, 12'h810, 1'b1, 1'b0);
		c.noise_rej = 1'b0;
		go(c, 12'h7f0, 12'h804, 1'b1, 1'b0);
		// The slow path lags a step: a short burst stays below the level, a long one crosses.
		c.filt = ATC_F_HIGH_BAND_BLOCK;
		code <= 12'h100;
		ahb(1'b1, ATC_SETUP, 32'(c));
		ahb(1'b1, ATC_CTRL, 32'h3);
		samples(12'h100, 40);
		pulses = 0;
		samples(12'hf00, 4);
		check(32'(pulses), 32'h0, "slow path blocks burst");
		samples(12'hf00, 24);
		check(32'(pulses), 32'h1, "slow path follows step");
		ahb(1'b1, ATC_CTRL, 32'h10);
		c.filt = ATC_F_OFF;
		c.kind = ATC_K_ANALOG;
		gap <= 2'h3;
		kind <= ATC_K_ANALOG;
		code <= 12'h100;
		ahb(1'b1, ATC_SETUP, 32'(c));
		ahb(1'b1, ATC_CTRL, 32'h3);
		samples(12'h100, 4);
		samples(12'hf00, 1);
		ahb(1'b1, ATC_CTRL, 32'h2);
		check({31'h0, capturing}, 32'h1, "capture after run off");
		samples(12'h100, 8);
		check({31'h0, capturing}, 32'h0, "capture stopped");
		ahb(1'b0, ATC_STATUS, 32'h0);
		check({16'h0, rd[15:8], 5'h0, rd[2:0]}, 32'h100, "idle after capture");
		ahb(1'b0, ATC_TRIGPOS, 32'h0);
		ahb(1'b1, ATC_RDIDX, rd);
		ahb(1'b0, ATC_RDDATA, 32'h0);
		check(rd, 32'hf00, "trigger sample kept");
		ahb(1'b0, ATC_TRIGPOS, 32'h0);
		ahb(1'b1, ATC_RDIDX, rd - 32'h1);
		ahb(1'b0, ATC_RDDATA, 32'h0);
		check(rd, 32'h100, "pre-trigger sample kept");
		give_verdict();
	end
endmodule
`default_nettype wire
